// ---- hw/gas_sensor_output_interface.sv ----
`timescale 1ns/1ps
// How it works
// - The PWM pin is driven push-pull with a fixed period of 1004 ms.
// - The high pulse lasts between 2 ms and 1002 ms, covering 0 to 5000 ppm.
// - Alarm releases above 1000 ppm, pulls low below 800 ppm, and holds in between.
// - Any internal error keeps the alarm released.
// - The alarm pin is open-drain only and never drives high.
// - The select pin is sampled only just after power-on; grounded means I2C.
// - At power-on the select pin is an input with pull-up, so floating means UART.
// - In UART mode the select pin serves as an open-drain RS485 direction output.
// - In I2C mode both host pins become open-drain data and clock lines.
// - Self-calibration repeats every 168 h by default, settable from 24 h to 720 h.
// - The first self-calibration comes within 24 h of power-on, then the interval applies.
// - UART characters run at 9600 bit/s.
// - The manual calibration input has a pull-up from power-on.
module gas_sensor_output_interface
  import gas_out_pkg::*;
#(
  parameter longint unsigned HOUR_CYC = HOUR_CYC_DEF
)(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Measurement and status from the core
  input  wire logic [15:0] ppm_i,
  input  wire logic        error_i,
  // Calibration control
  input  wire logic [9:0]  cal_hours_i,
  input  wire logic        cal_hours_wr_i,
  input  wire logic        cal_enable_i,
  input  wire logic        cal_done_i,
  output logic             cal_request_o,
  output logic [1:0]       cal_hours_status_o,
  output logic [9:0]       cal_hours_o,
  // Manual calibration pin
  input  wire logic        manual_cal_input_i,
  output logic             manual_cal_pullup_o,
  output logic             manual_cal_pressed_o,
  // Outputs
  output logic             pwm_o,
  output logic             alarm_open_drain_out_o,
  output logic             alarm_open_drain_out_oe_o,
  // Select / RS485 direction pin
  input  wire logic        dir_sel_i,
  output logic             dir_sel_o,
  output logic             dir_sel_oe_o,
  output logic             dir_sel_pullup_o,
  output logic             i2c_mode_o,
  // Host pins
  input  wire logic        host_tx_or_i2c_data_i,
  output logic             host_tx_or_i2c_data_o,
  output logic             host_tx_or_i2c_data_oe_o,
  input  wire logic        host_rx_or_i2c_clock_i,
  output logic             host_rx_or_i2c_clock_o,
  output logic             host_rx_or_i2c_clock_oe_o,
  // Byte send path for UART and I2C data drive from the protocol engine
  input  wire logic [7:0]  tx_byte_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  input  wire logic        i2c_sda_low_i,
  input  wire logic        i2c_scl_low_i,
  output logic [2:0]       host_rx_sync_o
);

  localparam int unsigned PWM_W = $clog2(PWM_PERIOD_CYC);
  localparam int unsigned HOUR_W = $clog2(HOUR_CYC + 1);
  localparam int unsigned BIT_W = $clog2(BIT_CYC);
  localparam logic [PWM_W-1:0] PERIOD_LAST = PWM_W'(PWM_PERIOD_CYC - 1);
  localparam logic [PWM_W-1:0] MIN_CYC = PWM_W'(PWM_MIN_MS * CYC_PER_MS);
  localparam logic [31:0] SPAN_CYC = 32'(PWM_SPAN_MS * CYC_PER_MS);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(BIT_CYC - 1);
  localparam logic [HOUR_W-1:0] HOUR_LAST = HOUR_W'(HOUR_CYC - 1);

  // Pin synchronisers: three stages, a change counts once stages 2 and 3 agree
  logic [2:0] sel_sync;
  logic [2:0] cal_sync;
  logic       cal_level;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      sel_sync  <= 3'b111;
      cal_sync  <= 3'b111;
      cal_level <= 1'b1;
    end
    else
    begin
      sel_sync <= {sel_sync[1:0], dir_sel_i};
      cal_sync <= {cal_sync[1:0], manual_cal_input_i};
      if (cal_sync[1] == cal_sync[2])
        cal_level <= cal_sync[2];
    end
  end

  // Strap capture: a few cycles after release, then frozen so later grounding is ignored
  logic [2:0] strap_cnt;
  logic       strap_done;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      strap_cnt  <= 3'h0;
      strap_done <= 1'b0;
      i2c_mode_o <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_cnt <= strap_cnt + 3'h1;
      if (strap_cnt == 3'h4 && sel_sync[1] == sel_sync[2])
      begin
        strap_done <= 1'b1;
        i2c_mode_o <= ~sel_sync[2];
      end
      else if (strap_cnt == 3'h4)
        strap_cnt <= 3'h3;
    end
  end

  // Pull-ups on select and manual-cal pins are on from power-on; the select one drops once UART mode is strapped
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      dir_sel_pullup_o     <= 1'b1;
      manual_cal_pullup_o  <= 1'b1;
      manual_cal_pressed_o <= 1'b0;
    end
    else
    begin
      dir_sel_pullup_o     <= ~strap_done | i2c_mode_o;
      manual_cal_pullup_o  <= 1'b1;
      manual_cal_pressed_o <= ~cal_level;
    end
  end

  // PWM period counter and clamped, linear pulse width
  logic [PWM_W-1:0] pwm_cnt;
  logic [PWM_W-1:0] high_cyc;
  logic [15:0]      ppm_clamped;
  logic [47:0]      scaled;
  always_comb
  begin
    ppm_clamped = (ppm_i > PPM_SPAN) ? PPM_SPAN : ppm_i;
    scaled      = 48'(ppm_clamped) * 48'(SPAN_CYC) / 48'(PPM_SPAN);
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      pwm_cnt  <= '0;
      high_cyc <= MIN_CYC;
      pwm_o    <= 1'b0;
    end
    else
    begin
      if (pwm_cnt == PERIOD_LAST)
      begin
        pwm_cnt  <= '0;
        high_cyc <= MIN_CYC + PWM_W'(scaled);
      end
      else
        pwm_cnt <= pwm_cnt + 1'b1;
      pwm_o <= (pwm_cnt < high_cyc);
    end
  end

  // Alarm with hysteresis; released means oe low, output data always low
  logic alarm_high;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      alarm_high <= 1'b0;
    else if (ppm_i > ALARM_HI_PPM)
      alarm_high <= 1'b1;
    else if (ppm_i < ALARM_LO_PPM)
      alarm_high <= 1'b0;
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      alarm_open_drain_out_o    <= 1'b0;
      alarm_open_drain_out_oe_o <= 1'b1;
    end
    else
    begin
      alarm_open_drain_out_o    <= 1'b0;
      alarm_open_drain_out_oe_o <= ~(alarm_high | error_i);
    end
  end

  // Self-calibration scheduler: hour tick, first run at 24 h, then the interval
  logic [HOUR_W-1:0] hour_cyc_cnt;
  logic [9:0]        hour_cnt;
  logic              first_done;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      cal_hours_o        <= CAL_DEF_H;
      cal_hours_status_o <= 2'h0;
    end
    else if (cal_hours_wr_i)
    begin
      if (cal_hours_i < CAL_MIN_H)
        cal_hours_status_o <= 2'h1;
      else if (cal_hours_i > CAL_MAX_H)
        cal_hours_status_o <= 2'h2;
      else
      begin
        cal_hours_status_o <= 2'h0;
        cal_hours_o        <= cal_hours_i;
      end
    end
  end
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      hour_cyc_cnt  <= '0;
      hour_cnt      <= 10'h000;
      first_done    <= 1'b0;
      cal_request_o <= 1'b0;
    end
    else
    begin
      // Request stays up until the core reports completion; a new request raised in the same cycle wins over done
      if (cal_done_i)
        cal_request_o <= 1'b0;
      if (hour_cyc_cnt == HOUR_LAST)
      begin
        hour_cyc_cnt <= '0;
        if (hour_cnt + 10'h001 >= (first_done ? cal_hours_o : CAL_FIRST_H))
        begin
          hour_cnt   <= 10'h000;
          first_done <= 1'b1;
          if (cal_enable_i)
            cal_request_o <= 1'b1;
        end
        else
          hour_cnt <= hour_cnt + 10'h001;
      end
      else
        hour_cyc_cnt <= hour_cyc_cnt + 1'b1;
    end
  end

  // UART transmitter at 9600 bit/s, 8N1 LSB first
  tx_state_t  tx_state;
  logic [BIT_W-1:0] bit_cnt;
  logic [3:0] bit_idx;
  logic [7:0] tx_shift;
  logic       tx_line;
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      tx_state   <= TX_IDLE;
      bit_cnt    <= '0;
      bit_idx    <= 4'h0;
      tx_shift   <= 8'h00;
      tx_line    <= 1'b1;
      tx_ready_o <= 1'b0;
    end
    else
    begin
      tx_ready_o <= (tx_state == TX_IDLE) && !i2c_mode_o && strap_done && !tx_valid_i;
      case (tx_state)
        TX_IDLE:
          if (tx_ready_o && tx_valid_i)
          begin
            tx_shift   <= tx_byte_i;
            tx_line    <= 1'b0;
            bit_cnt    <= '0;
            tx_state   <= TX_START;
            tx_ready_o <= 1'b0;
          end
        TX_START, TX_DATA:
          if (bit_cnt == BIT_LAST)
          begin
            bit_cnt  <= '0;
            tx_line  <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[7:1]};
            bit_idx  <= (tx_state == TX_START) ? 4'h1 : bit_idx + 4'h1;
            if (tx_state == TX_DATA && bit_idx == UART_BITS - 4'h1)
            begin
              tx_line  <= 1'b1;
              tx_state <= TX_STOP;
            end
            else
              tx_state <= TX_DATA;
          end
          else
            bit_cnt <= bit_cnt + 1'b1;
        TX_STOP:
          if (bit_cnt == BIT_LAST)
          begin
            bit_cnt  <= '0;
            tx_state <= TX_IDLE;
          end
          else
            bit_cnt <= bit_cnt + 1'b1;
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // Pin drive per mode; RS485 direction asserts (released high) while sending
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      host_tx_or_i2c_data_o     <= 1'b1;
      host_tx_or_i2c_data_oe_o  <= 1'b0;
      host_rx_or_i2c_clock_o    <= 1'b0;
      host_rx_or_i2c_clock_oe_o <= 1'b0;
      dir_sel_o                 <= 1'b0;
      dir_sel_oe_o              <= 1'b0;
      host_rx_sync_o            <= 3'b111;
    end
    else
    begin
      host_rx_sync_o <= {host_rx_sync_o[1:0],
                         i2c_mode_o ? host_tx_or_i2c_data_i : host_rx_or_i2c_clock_i};
      host_rx_or_i2c_clock_o <= 1'b0;
      if (i2c_mode_o)
      begin
        host_tx_or_i2c_data_o     <= 1'b0;
        host_tx_or_i2c_data_oe_o  <= i2c_sda_low_i;
        host_rx_or_i2c_clock_oe_o <= i2c_scl_low_i;
        dir_sel_oe_o              <= 1'b0;
      end
      else
      begin
        host_tx_or_i2c_data_o     <= tx_line;
        host_tx_or_i2c_data_oe_o  <= strap_done;
        host_rx_or_i2c_clock_oe_o <= 1'b0;
        dir_sel_oe_o              <= strap_done && (tx_state == TX_IDLE);
      end
      dir_sel_o <= 1'b0;
    end
  end

endmodule // gas_sensor_output_interface

// ---- hw/gas_out_pkg.sv ----
package gas_out_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned PWM_PERIOD_MS   = 1004;
  localparam int unsigned PWM_MIN_MS      = 2;
  localparam int unsigned PWM_SPAN_MS     = 1000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned PWM_PERIOD_CYC  = PWM_PERIOD_MS * CYC_PER_MS;
  localparam int unsigned BAUD_BPS        = 9600;
  localparam int unsigned BIT_CYC         = CLK_HZ / BAUD_BPS;
  localparam int unsigned SEC_PER_HOUR    = 3600;
  // One hour of cycles does not fit 32 bits, so it is reckoned in 64
  localparam longint unsigned HOUR_CYC_DEF = 64'(SEC_PER_HOUR) * 64'(CLK_HZ);
  // Concentration span and alarm thresholds in ppm
  localparam logic [15:0] PPM_SPAN        = 16'h1388;
  localparam logic [15:0] ALARM_HI_PPM    = 16'h03E8;
  localparam logic [15:0] ALARM_LO_PPM    = 16'h0320;
  // Self-calibration interval in hours
  localparam logic [9:0]  CAL_DEF_H       = 10'h0A8;
  localparam logic [9:0]  CAL_MIN_H       = 10'h018;
  localparam logic [9:0]  CAL_MAX_H       = 10'h2D0;
  localparam logic [9:0]  CAL_FIRST_H     = 10'h018;
  // UART framing
  localparam logic [3:0]  UART_BITS       = 4'h9;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11,
                            TX_STOP = 2'b10} tx_state_t;
endpackage

// ---- dv/host_uart_model.sv ----
`timescale 1ns/1ps
module host_uart_model
  import gas_out_pkg::*;
#(
  parameter int unsigned NB = 8
)(
  // Clock
  input  wire logic       sys_clk_i,
  // Device transmit line
  input  wire logic       line_i,
  // Bits received, first bit in bit 0
  output logic [7:0]      rx_bits_o,
  output logic            rx_done_o
);
  // Mid-bit sampling; a start bit that is high again at mid-bit is taken as a glitch
  initial
  begin
    rx_bits_o = 8'h00;
    rx_done_o = 1'b0;
    forever
    begin
      @(negedge line_i);
      repeat (BIT_CYC / 2) @(posedge sys_clk_i);
      if (line_i == 1'b0)
      begin
        for (int i = 0; i < NB; i++)
        begin
          repeat (BIT_CYC) @(posedge sys_clk_i);
          rx_bits_o[i] = line_i;
        end
        rx_done_o = 1'b1;
      end
    end
  end
endmodule // host_uart_model

// ---- dv/gas_sensor_output_interface_sva.sv ----
`timescale 1ns/1ps
module gas_out_sva
  import gas_out_pkg::*;
(
  // Watched ports
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [15:0] ppm_i,
  input wire logic        error_i,
  input wire logic [9:0]  cal_hours_i,
  input wire logic        cal_hours_wr_i,
  input wire logic [1:0]  cal_hours_status_o,
  input wire logic [9:0]  cal_hours_o,
  input wire logic        manual_cal_pullup_o,
  input wire logic        alarm_open_drain_out_o,
  input wire logic        alarm_open_drain_out_oe_o,
  input wire logic        dir_sel_o,
  input wire logic        i2c_mode_o,
  input wire logic        host_tx_or_i2c_data_o,
  input wire logic        host_rx_or_i2c_clock_o,
  input wire logic        tx_valid_i,
  input wire logic        tx_ready_o
);
  // One clock domain, so clock and disable are given once
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_alarm_set:
    assert property ((ppm_i > ALARM_HI_PPM && !error_i) [*2] |=> !alarm_open_drain_out_oe_o)
    else $error("alarm not released");
  a_alarm_clear:
    assert property ((ppm_i < ALARM_LO_PPM && !error_i) [*2] |=> alarm_open_drain_out_oe_o)
    else $error("alarm not pulled low");
  a_alarm_hold:
    assert property ((ppm_i >= ALARM_LO_PPM && ppm_i <= ALARM_HI_PPM && !error_i) [*3]
      |=> $stable(alarm_open_drain_out_oe_o)) else $error("alarm moved in band");
  a_error_release:
    assert property (error_i |=> !alarm_open_drain_out_oe_o) else $error("error not released");
  a_pins_od:
    assert property (!alarm_open_drain_out_o && !dir_sel_o) else $error("open drain drives high");
  a_mode_held:
    assert property ((i2c_mode_o || tx_ready_o) |=> $stable(i2c_mode_o)) else $error("mode moved");
  a_i2c_pins:
    assert property (i2c_mode_o |=> !host_tx_or_i2c_data_o && !host_rx_or_i2c_clock_o && !tx_ready_o)
    else $error("i2c pins not open drain");
  a_hours_range:
    assert property (cal_hours_o >= CAL_MIN_H && cal_hours_o <= CAL_MAX_H) else $error("hours range");
  a_hours_bad:
    assert property (cal_hours_wr_i && (cal_hours_i < CAL_MIN_H || cal_hours_i > CAL_MAX_H)
      |=> $stable(cal_hours_o) && cal_hours_status_o == ($past(cal_hours_i) < CAL_MIN_H ? 2'h1 : 2'h2))
    else $error("bad hours taken");
  a_hours_ok:
    assert property (cal_hours_wr_i && cal_hours_i >= CAL_MIN_H && cal_hours_i <= CAL_MAX_H
      |=> cal_hours_o == $past(cal_hours_i) && cal_hours_status_o == 2'h0) else $error("hours lost");
  a_tx_start:
    assert property (tx_ready_o && tx_valid_i |-> ##[1:2] !host_tx_or_i2c_data_o) else $error("no start");
  a_cal_pullup:
    assert property (manual_cal_pullup_o) else $error("pull-up off");
endmodule // gas_out_sva
bind gas_sensor_output_interface gas_out_sva gas_out_sva_i (.*);

// ---- dv/gas_sensor_output_interface_bench.sv ----
`timescale 1ns/1ps
module gas_sensor_output_interface_bench;
  import gas_out_pkg::*;
  // Short hour keeps the calibration schedule inside the run
  localparam int unsigned HC = 100;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [15:0] ppm_i = 16'h0000;
  logic [9:0]  cal_hours_i = 10'h0A8;
  logic [7:0]  tx_byte_i = 8'h00;
  logic        error_i = 1'b0, cal_hours_wr_i = 1'b0, cal_enable_i = 1'b1, cal_done_i = 1'b0;
  logic        tx_valid_i = 1'b0, i2c_sda_low_i = 1'b0, i2c_scl_low_i = 1'b0;
  logic        manual_pin = 1'b1, strap_gnd = 1'b0;
  wire         cal_request_o, manual_cal_pullup_o, manual_cal_pressed_o, pwm_o, tx_ready_o;
  wire         alarm_open_drain_out_o, alarm_open_drain_out_oe_o, dir_sel_o, dir_sel_oe_o;
  wire         dir_sel_pullup_o, i2c_mode_o, host_tx_or_i2c_data_o, host_tx_or_i2c_data_oe_o;
  wire         host_rx_or_i2c_clock_o, host_rx_or_i2c_clock_oe_o, rx_done;
  wire [1:0]   cal_hours_status_o;
  wire [9:0]   cal_hours_o;
  wire [2:0]   host_rx_sync_o;
  wire [7:0]   rx_bits;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0;
  // Pins resolved with external pull-ups; strap_gnd grounds the select pin
  wire dir_line = !((dir_sel_oe_o && !dir_sel_o) || strap_gnd);
  wire tx_line  = host_tx_or_i2c_data_oe_o ? host_tx_or_i2c_data_o : 1'b1;
  wire rx_line  = host_rx_or_i2c_clock_oe_o ? host_rx_or_i2c_clock_o : 1'b1;
  gas_sensor_output_interface #(.HOUR_CYC(HC)) gas_sensor_output_interface_i (
    .dir_sel_i(dir_line), .manual_cal_input_i(manual_pin), .host_tx_or_i2c_data_i(tx_line),
    .host_rx_or_i2c_clock_i(rx_line), .*);
  host_uart_model #(.NB(3)) host_uart_model_i (
    .sys_clk_i(sys_clk_i), .line_i(tx_line), .rx_bits_o(rx_bits), .rx_done_o(rx_done));
  // Clock and hang guard
  always #2.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic do_reset(input logic gnd);
    rst_n_i = 1'b0;
    strap_gnd = gnd;
    tick(6);
    rst_n_i = 1'b1;
    tick(12);
  endtask
  task automatic t_reset();
    tick(6);
    chk("hours_rst", 16'h00A8, 16'(cal_hours_o));
    chk("pullups", 16'h0003, 16'({manual_cal_pullup_o, dir_sel_pullup_o}));
    rst_n_i = 1'b1;
    tick(12);
    chk("uart_sel", 16'h0002, 16'({i2c_mode_o, tx_ready_o, dir_line}));
    $display("t_reset done");
  endtask
  task automatic t_alarm();
    logic [15:0] pv [6] = '{16'h03E9, 16'h0320, 16'h031F, 16'h03E8, 16'h03E8, 16'h0000};
    logic [5:0]  ev = 6'h10;
    logic [5:0]  xv = 6'h2C;
    for (int i = 0; i < 6; i++)
    begin
      ppm_i = pv[i];
      error_i = ev[i];
      tick(3);
      chk("alarm_oe", 16'(xv[i]), 16'(alarm_open_drain_out_oe_o));
    end
    manual_pin = 1'b0;
    tick(8);
    chk("manual", 16'h0001, 16'(manual_cal_pressed_o));
    manual_pin = 1'b1;
    tick(8);
    chk("manual", 16'h0000, 16'(manual_cal_pressed_o));
    $display("t_alarm done");
  endtask
  // Back-to-back writes, both ends of the range and one past each
  task automatic t_cal_hours();
    logic [9:0] hv [5] = '{10'h017, 10'h2D1, 10'h018, 10'h2D0, 10'h0A8};
    logic [9:0] eh = 10'h0A8;
    logic [1:0] es;
    cal_hours_wr_i = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      cal_hours_i = hv[i];
      es = hv[i] < CAL_MIN_H ? 2'h1 : (hv[i] > CAL_MAX_H ? 2'h2 : 2'h0);
      if (es == 2'h0)
        eh = hv[i];
      tick(1);
      chk("hours", 16'(eh), 16'(cal_hours_o));
      chk("status", 16'(es), 16'(cal_hours_status_o));
    end
    cal_hours_wr_i = 1'b0;
    $display("t_cal_hours done");
  endtask
  // Only the start and first three data bits fit the run
  task automatic t_uart();
    for (int n = 0; n < 100 && tx_ready_o !== 1'b1; n++)
      tick(1);
    tx_byte_i = 8'hA5;
    tx_valid_i = 1'b1;
    tick(1);
    tx_valid_i = 1'b0;
    tick(4);
    chk("frame", 16'h0000, 16'({dir_sel_oe_o, tx_line}));
    for (int n = 0; n < 80000 && rx_done !== 1'b1; n++)
      tick(1);
    chk("bits", 16'h0005, 16'(rx_bits[2:0]));
    $display("t_uart done");
  endtask
  task automatic t_strap();
    do_reset(1'b1);
    strap_gnd = 1'b0;
    i2c_sda_low_i = 1'b1;
    tick(3);
    chk("i2c_sda", 16'h000A, 16'({i2c_mode_o, tx_line, rx_line, tx_ready_o}));
    chk("rx_sync", 16'h0004, 16'(host_rx_sync_o));
    i2c_sda_low_i = 1'b0;
    i2c_scl_low_i = 1'b1;
    tick(3);
    chk("i2c_scl", 16'h000C, 16'({i2c_mode_o, tx_line, rx_line, tx_ready_o}));
    i2c_scl_low_i = 1'b0;
    do_reset(1'b0);
    strap_gnd = 1'b1;
    tick(6);
    chk("late_gnd", 16'h0001, 16'({i2c_mode_o, tx_ready_o}));
    strap_gnd = 1'b0;
    $display("t_strap done");
  endtask
  task automatic t_schedule();
    int n;
    do_reset(1'b0);
    for (n = 0; n < 3000 && cal_request_o !== 1'b1; n++)
      tick(1);
    chk("first_cal", 16'h0001, 16'(n > 2300 && n < 2500));
    cal_done_i = 1'b1;
    cal_hours_i = 10'h018;
    cal_hours_wr_i = 1'b1;
    tick(1);
    cal_done_i = 1'b0;
    cal_hours_wr_i = 1'b0;
    chk("cal_clear", 16'h0000, 16'(cal_request_o));
    for (n = 0; n < 3000 && cal_request_o !== 1'b1; n++)
      tick(1);
    chk("next_cal", 16'h0001, 16'(n > 2300 && n < 2500));
    // With self-calibration disabled no request may follow the next due hour
    cal_enable_i = 1'b0;
    cal_done_i = 1'b1;
    tick(1);
    cal_done_i = 1'b0;
    for (n = 0; n < 2500 && cal_request_o !== 1'b1; n++)
      tick(1);
    chk("cal_off", 16'h0000, 16'(cal_request_o));
    cal_enable_i = 1'b1;
    $display("t_schedule done");
  endtask
  initial
  begin
    t_reset();
    t_alarm();
    t_cal_hours();
    t_uart();
    t_strap();
    t_schedule();
    test_done();
  end
endmodule // gas_sensor_output_interface_bench
